// [core/rx_signal_loss_alarm_pkg.sv]
// package for the receive loss-of-signal detector: constants and carriers
package rlsd_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;       // i_clk period in ns

  // ----------------------------------------------------------------------
  // zero-run thresholds for declaring loss
  // ----------------------------------------------------------------------
  localparam int E1_LOSS_ZEROS  = 32;       // e1 normal zero run
  localparam int EXT_LOSS_ZEROS = 4096;     // e1 extended zero run
  localparam int T1_LOSS_ZEROS  = 175;      // t1 zero run

  // ----------------------------------------------------------------------
  // ones-density criteria for clearing loss
  // ----------------------------------------------------------------------
  localparam int E1_WIN_BITS   = 32;        // e1 density window
  localparam int E1_WIN_ONES   = 4;         // e1 least ones per window
  localparam int E1_MAX_ZEROS  = 16;        // e1 longest allowed run
  localparam int T1_WIN_BITS   = 128;       // t1 density window
  localparam int T1_WIN_ONES   = 16;        // t1 least ones per window
  localparam int T1_MAX_ZEROS  = 100;       // t1 longest allowed run

  // ----------------------------------------------------------------------
  // counter widths
  // ----------------------------------------------------------------------
  localparam int RUN_W = 13;                // holds up to 4096 and more
  localparam int WIN_W = 8;                 // holds up to 128

  // ----------------------------------------------------------------------
  // detector states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RLSD_ST_OK   = 2'b01,                   // signal present
    RLSD_ST_LOST = 2'b10                    // loss declared
  } rlsd_state_t;

  // per-channel received bit with its qualifiers
  typedef struct packed {
    logic bit_valid;                        // one recovered bit this cycle
    logic data;                             // recovered data value
    logic low_level;                        // analog low-signal indication
    logic level_ok;                         // analog recovered past hysteresis
  } rlsd_rx_t;

  // per-channel status toward software
  typedef struct packed {
    logic live;                             // live loss indication
    logic latched;                          // latched alarm status
    logic irq;                              // enabled interrupt request
  } rlsd_stat_t;

endpackage

// [core/rx_signal_loss_alarm_chan.sv]
// one channel of the receive loss-of-signal detector
`timescale 1ns/100ps
`default_nettype none
module rlsd_chan
  import rlsd_pkg::*;
(
  input  wire logic       i_clk,            // receive clock
  input  wire logic       i_rst_b,          // sync reset, active low
  input  wire rlsd_rx_t   i_rx,             // received bit and analog flags
  input  wire logic       i_e1_mode,        // 1 = e1, 0 = t1
  input  wire logic       i_ext_sel,        // extended loss window select
  input  wire logic       i_irq_en,         // interrupt enable
  input  wire logic       i_status_rd,      // status read strobe
  output var rlsd_stat_t  o_stat            // live, latched, irq
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  rlsd_state_t      state, next_state;      // detector state
  logic [RUN_W-1:0] zrun, next_zrun;        // consecutive zeros
  logic [WIN_W-1:0] wbits, next_wbits;      // bits in current window
  logic [WIN_W-1:0] wones, next_wones;      // ones in current window
  logic             wgood, next_wgood;      // a good window was seen
  logic             latched, next_latched;  // latched alarm

  logic [RUN_W-1:0] loss_lim;               // selected loss threshold
  logic [RUN_W-1:0] max_run;                // clear-side run limit
  logic [WIN_W-1:0] win_len;                // window length
  logic [WIN_W-1:0] win_ones;               // required ones

  // ----------------------------------------------------------------------
  // threshold selection
  // ----------------------------------------------------------------------
  always_comb begin
    if (i_e1_mode) begin
      loss_lim = i_ext_sel ? RUN_W'(EXT_LOSS_ZEROS)
                           : RUN_W'(E1_LOSS_ZEROS);
      max_run  = RUN_W'(E1_MAX_ZEROS);
      win_len  = WIN_W'(E1_WIN_BITS);
      win_ones = WIN_W'(E1_WIN_ONES);
    end else begin
      loss_lim = RUN_W'(T1_LOSS_ZEROS);     // extended ignored
      max_run  = RUN_W'(T1_MAX_ZEROS);
      win_len  = WIN_W'(T1_WIN_BITS);
      win_ones = WIN_W'(T1_WIN_ONES);
    end
  end

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    next_state   = state;
    next_zrun    = zrun;
    next_wbits   = wbits;
    next_wones   = wones;
    next_wgood   = wgood;
    next_latched = latched;
    if (i_rx.bit_valid) begin
      // zero run: a one restarts it
      if (i_rx.data) next_zrun = '0;
      else if (zrun != {RUN_W{1'b1}}) next_zrun = zrun + RUN_W'(1);
    end
    unique case (state)
      RLSD_ST_OK: begin
        next_wbits = '0;
        next_wones = '0;
        next_wgood = 1'b0;
        if (!i_rx.low_level) begin
          next_zrun = '0;                   // analog fine: no count
        end else if (i_rx.bit_valid && !i_rx.data) begin
          if (next_zrun >= loss_lim) begin
            next_state   = RLSD_ST_LOST;
            next_latched = 1'b1;
          end
        end
      end
      RLSD_ST_LOST: begin
        if (!i_rx.level_ok) begin
          next_wbits = '0;                  // analog not recovered
          next_wones = '0;
          next_wgood = 1'b0;
        end else if (i_rx.bit_valid) begin
          if (!i_rx.data && next_zrun > max_run) begin
            next_wbits = '0;                // run too long
            next_wones = '0;
            next_wgood = 1'b0;
          end else if (wbits + WIN_W'(1) == win_len) begin
            // window closes: check density
            next_wbits = '0;
            next_wones = '0;
            if (wones + WIN_W'(i_rx.data) >= win_ones) begin
              if (wgood) begin
                next_state = RLSD_ST_OK;    // two clean windows in a row
                next_zrun  = '0;
              end
              next_wgood = 1'b1;
            end else begin
              next_wgood = 1'b0;
            end
          end else begin
            next_wbits = wbits + WIN_W'(1);
            next_wones = wones + WIN_W'(i_rx.data);
          end
        end
      end
    endcase
    // clear on read; a new declaration wins
    if (i_status_rd && !(state == RLSD_ST_OK && next_state == RLSD_ST_LOST))
      next_latched = 1'b0;
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state   <= RLSD_ST_OK;
      zrun    <= '0;
      wbits   <= '0;
      wones   <= '0;
      wgood   <= 1'b0;
      latched <= 1'b0;
    end else begin
      state   <= next_state;
      zrun    <= next_zrun;
      wbits   <= next_wbits;
      wones   <= next_wones;
      wgood   <= next_wgood;
      latched <= next_latched;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign o_stat.live    = (state == RLSD_ST_LOST);
  assign o_stat.latched = latched;
  assign o_stat.irq     = latched & i_irq_en;

endmodule
`default_nettype wire

// [core/rx_signal_loss_alarm_top.sv]
// multi-channel receive loss-of-signal detector, top level
//
// Overview of operation
// - e1 declares loss after 32 zeros
// - extended select needs 4096 zeros instead
// - t1 declares loss after 175 zeros
// - e1 clears on 4 ones/32, run<=16
// - t1 clears on 16 ones/128, run<=100
// - declaration updates live and latched status
// - enabled alarm drives interrupt low
// - status read clears alarm, releases interrupt
// - extended mode only in e1 operation
`timescale 1ns/100ps
`default_nettype none
module rlsd_top
  import rlsd_pkg::*;
#(
  parameter int NCH = 8                     // receive channels
) (
  input  wire logic           i_clk,        // recovered receive clock
  input  wire logic           i_rst_b,      // sync reset, active low
  input  wire rlsd_rx_t [NCH-1:0] i_rx,     // per-channel received bits
  input  wire logic           i_e1_mode,    // 1 = e1, 0 = t1 (global)
  input  wire logic [NCH-1:0] i_extended_loss_window_select, // per channel
  input  wire logic [NCH-1:0] i_irq_en,     // per-channel interrupt enable
  input  wire logic           i_status_rd,  // read of alarm status, pulse
  output logic [NCH-1:0]      o_rx_signal_loss_alarm,  // live indication
  output logic [NCH-1:0]      o_status,     // latched alarm status
  output logic                o_int_b,      // interrupt, active low
  output logic                o_int_oe      // open-drain enable
);

  // ----------------------------------------------------------------------
  // channel detectors
  // ----------------------------------------------------------------------
  rlsd_stat_t [NCH-1:0] stat;               // per-channel status

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    // one independent detector per channel
    rlsd_chan u_chan (
      .i_clk       (i_clk),
      .i_rst_b     (i_rst_b),
      .i_rx        (i_rx[c]),
      .i_e1_mode   (i_e1_mode),
      .i_ext_sel   (i_extended_loss_window_select[c]),
      .i_irq_en    (i_irq_en[c]),
      .i_status_rd (i_status_rd),
      .o_stat      (stat[c])
    );
    assign o_rx_signal_loss_alarm[c] = stat[c].live;
    assign o_status[c]               = stat[c].latched;
  end

  // ----------------------------------------------------------------------
  // combined interrupt
  // ----------------------------------------------------------------------
  logic irq_any, next_irq_any;              // registered any-request

  always_comb begin
    next_irq_any = 1'b0;
    for (int c = 0; c < NCH; c++)
      next_irq_any = next_irq_any | stat[c].irq;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) irq_any <= 1'b0;
    else irq_any <= next_irq_any;
  end

  assign o_int_b  = 1'b0;                   // pulled low only when enabled
  assign o_int_oe = irq_any;                // released high after read

endmodule
`default_nettype wire

// [sim/rx_signal_loss_alarm_top_sva.sv]
// checker: loss-of-signal detector port assertions
`timescale 1ns/100ps
`default_nettype none
module rlsd_top_sva
  import rlsd_pkg::*;
#(parameter int NCH = 8) (
  input wire logic               i_clk,
  input wire logic               i_rst_b,
  input wire rlsd_rx_t [NCH-1:0] i_rx,
  input wire logic               i_e1_mode,
  input wire logic [NCH-1:0]     i_extended_loss_window_select,
  input wire logic [NCH-1:0]     i_irq_en,
  input wire logic               i_status_rd,
  input wire logic [NCH-1:0]     o_rx_signal_loss_alarm,
  input wire logic [NCH-1:0]     o_status,
  input wire logic               o_int_b,
  input wire logic               o_int_oe
);
  // ------------------------------------------------------------------
  // helper: channel 0 zero run, per-channel bit qualifiers
  // ------------------------------------------------------------------
  logic [RUN_W-1:0] zc, next_zc;  // zeros in a row, channel 0
  logic [NCH-1:0]   zl, ok, lv;   // low-level zero, level ok, live
  logic [2:0]       arm;          // ch0 may declare: e1, t1, extended
  logic             irq;          // enabled latched alarm
  always_comb begin
    lv = o_rx_signal_loss_alarm;
    irq = |(o_status & i_irq_en);
    next_zc = zc;
    if (!i_rx[0].low_level) next_zc = '0;
    else if (i_rx[0].bit_valid) next_zc = i_rx[0].data ? '0 : zc + 1'b1;
    for (int c = 0; c < NCH; c++) begin
      zl[c] = i_rx[c].bit_valid & ~i_rx[c].data & i_rx[c].low_level;
      ok[c] = i_rx[c].bit_valid & i_rx[c].level_ok;
    end
    arm[0] = i_e1_mode & ~i_extended_loss_window_select[0];
    arm[1] = ~i_e1_mode;
    arm[2] = i_e1_mode & i_extended_loss_window_select[0];
    arm = arm & {3{zl[0] & ~lv[0]}};
  end
  always_ff @(posedge i_clk) zc <= i_rst_b ? next_zc : '0;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  a_int_pin_low: assert property (o_int_b == 1'b0)
    else $error("interrupt data not low");
  a_int_follow: assert property ($past(i_rst_b) |->
    o_int_oe == $past(irq)) else $error("interrupt not tracking status");
  a_set_pair: assert property ((o_status & ~$past(o_status)) ==
    (lv & ~$past(lv) & ~$past(o_status)))
    else $error("status set apart from live");
  a_read_clear: assert property ($past(i_status_rd) |->
    o_status == (lv & ~$past(lv))) else $error("read left status set");
  a_status_hold: assert property ($past(i_rst_b) &&
    !$past(i_status_rd) |-> (o_status & $past(o_status)) == $past(o_status))
    else $error("status dropped without read");
  a_rise_on_zero: assert property (
    (lv & ~$past(lv) & ~$past(zl)) == '0) else $error("live without zero");
  a_fall_level_ok: assert property ($past(i_rst_b) |->
    (~lv & $past(lv) & ~$past(ok)) == '0) else $error("clear without level");
  a_e1_count: assert property ($past(arm[0]) |->
    lv[0] == ($past(zc) == E1_LOSS_ZEROS - 1)) else $error("e1 zero count");
  a_t1_count: assert property ($past(arm[1]) |->
    lv[0] == ($past(zc) == T1_LOSS_ZEROS - 1)) else $error("t1 zero count");
  a_ext_count: assert property ($past(arm[2]) |->
    lv[0] == ($past(zc) == EXT_LOSS_ZEROS - 1)) else $error("ext zero count");
  c_declare: cover property ($rose(lv[0]));
  c_clear: cover property ($fell(lv[0]));
  c_irq_release: cover property ($fell(o_int_oe));
endmodule
bind rlsd_top rlsd_top_sva #(.NCH(NCH)) u_sva (.i_clk(i_clk),
  .i_rst_b(i_rst_b), .i_rx(i_rx), .i_e1_mode(i_e1_mode),
  .i_extended_loss_window_select(i_extended_loss_window_select),
  .i_irq_en(i_irq_en), .i_status_rd(i_status_rd), .o_int_b(o_int_b),
  .o_rx_signal_loss_alarm(o_rx_signal_loss_alarm), .o_status(o_status),
  .o_int_oe(o_int_oe));
`default_nettype wire

// [sim/rx_signal_loss_alarm_line_model.sv]
// line-side model: recovered bits and analog level flags per pattern
`timescale 1ns/100ps
`default_nettype none
module rlsd_line_model
  import rlsd_pkg::*;
#(parameter int NCH = 8) (
  input  wire logic               i_clk,
  input  wire logic               i_rst_b,
  input  wire logic [1:0]         i_pat,   // 0 dead 1 thin 2 ones 3 sparse
  input  wire logic               i_slow,  // a bit every other cycle
  output wire rlsd_rx_t [NCH-1:0] o_rx
);
  logic [7:0] ph, next_ph;    // bit phase
  logic       vld, next_vld;  // bit strobe
  rlsd_rx_t   b;              // bit shared by all channels
  always_comb begin
    next_vld = i_slow ? ~vld : 1'b1;
    next_ph = ph + {7'h00, vld};
    b.bit_valid = vld;
    b.low_level = (i_pat == 2'h0);  // dead line only
    b.level_ok = i_pat[0];          // past hysteresis
    case (i_pat)
      2'h0: b.data = 1'b0;
      2'h1: b.data = (ph[6:0] == 7'h00);  // one in 128, runs too long
      2'h2: b.data = 1'b1;
      default: b.data = (ph[2:0] == 3'h0);  // 4 in 32, 16 in 128
    endcase
    if (!vld) b.data = ~b.data;  // no stale value between bits
  end
  always_ff @(posedge i_clk) begin
    ph <= i_rst_b ? next_ph : 8'h00;
    vld <= i_rst_b & next_vld;
  end
  assign o_rx = {NCH{b}};
endmodule
`default_nettype wire

// [sim/tb_receive_loss_of_signal_detector.sv]
// testbench: loss-of-signal declare, read and clear in each mode
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin \
  n_mismatch++; $display("BAD %0t %s", $time, m); end end
module tb_receive_loss_of_signal_detector;
  import rlsd_pkg::*;
  localparam int NCH = 8;
  logic           clk = 0, rst_b = 0, e1 = 0, rd = 0, slow = 0, ib, ioe;
  logic [1:0]     pat = 2'h2;  // line pattern
  logic [NCH-1:0] ext = '0, ien = '0, lv, st;
  wire rlsd_rx_t [NCH-1:0] rx;
  integer         checks = 0, n_mismatch = 0, seed = 32'h9451;
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  rlsd_line_model #(.NCH(NCH)) line (.i_clk(clk), .i_rst_b(rst_b),
    .i_pat(pat), .i_slow(slow), .o_rx(rx));
  rlsd_top #(.NCH(NCH)) uut (.i_clk(clk), .i_rst_b(rst_b), .i_rx(rx),
    .i_e1_mode(e1), .i_extended_loss_window_select(ext), .i_irq_en(ien),
    .i_status_rd(rd), .o_rx_signal_loss_alarm(lv), .o_status(st),
    .o_int_b(ib), .o_int_oe(ioe));
  // expected live mask after n zeros
  function automatic logic [NCH-1:0] exp_lv(int n);
    for (int c = 0; c < NCH; c++)
      exp_lv[c] = n >= (!e1 ? T1_LOSS_ZEROS :
                        ext[c] ? EXT_LOSS_ZEROS : E1_LOSS_ZEROS);
  endfunction
  task automatic go(logic [1:0] p);
    @(posedge clk);
    pat <= p;
  endtask
  // wait for an edge that takes a bit
  task automatic wbit;
    logic v;
    v = 1'b0;
    while (!v) begin
      @(posedge clk);
      v = rx[0].bit_valid;
    end
    #1;
  endtask
  task automatic zrun(int n);
    go(2'h0);
    for (int k = 1; k <= n; k++) begin
      wbit;
      `CHK(lv, exp_lv(k), "live")
      `CHK(st, exp_lv(k), "status")
    end
  endtask
  task automatic hold(int n, logic [NCH-1:0] e);
    repeat (n) begin
      wbit;
      `CHK(lv, e, "live held")
    end
  endtask
  task automatic run_test(logic e, logic s, logic [NCH-1:0] x);
    @(posedge clk);
    rst_b <= 1'b0;
    e1 <= e;
    slow <= s;
    ext <= x;
    ien <= NCH'($random(seed));
    pat <= 2'h2;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    zrun(E1_LOSS_ZEROS - 2);
    go(2'h1);
    wbit;
    zrun(!e ? T1_LOSS_ZEROS : |x ? EXT_LOSS_ZEROS : E1_LOSS_ZEROS);
    @(posedge clk);
    #1 `CHK(ioe, |ien, "irq raise")
    `CHK(ioe ? ib : 1'b1, ~|ien, "int pin low")
    @(posedge clk);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(st, '0, "status read")
    @(posedge clk);
    #1 `CHK(ioe, 1'b0, "irq release")
    `CHK(ioe ? ib : 1'b1, 1'b1, "int pin high")
    go(2'h2);
    hold(200, '1);
    go(2'h1);
    hold(300, '1); // thin line keeps the alarm
    go(2'h2);
    hold(1, '1); // level drop restarts windows
    go(2'h3);
    hold((e ? E1_WIN_BITS : T1_WIN_BITS) * 2 - 1, '1);
    hold(1, '0);
    `CHK(st, '0, "status after clear")
    $display("test e1=%0d slow=%0d done", e, s);
  endtask
  task automatic summarize;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    run_test(1'b1, 1'b0, NCH'($random(seed)) | 8'h01);
    run_test(1'b0, 1'b1, '1);
    run_test(1'b1, 1'b1, '0);
    summarize;
  end
  initial begin
    #(20000 * CLK_PERIOD_NS);
    n_mismatch++;
    summarize;
  end
endmodule
`default_nettype wire
